// [sim/core_access_model.sv]
// Model of the core pipeline that presents storage accesses.
`timescale 1ns/1ps

module core_access_model (
  input wire logic core_clk,
  output dac_dvc_pkg::access_t access
);
  // ****************************************************************
  // Access presentation.
  // ****************************************************************
  initial begin
    access = '0;
  end

  // Presents one access from the next clock edge, held until the next send or idle; sp is {second, first} part.
  task automatic send(input dac_dvc_pkg::acc_kind_t k, input logic [31:0] a,
    input logic [31:0] d, input logic [6:0] len, input logic [1:0] sp);
    @(posedge core_clk);
    access <= '{1'b1, k, a, d, len, sp[0], sp[1]};
  endtask

  // Drops the strobe; released address and data show the inverse value.
  task automatic idle();
    @(posedge core_clk);
    access.valid <= 1'b0;
    access.addr <= ~access.addr;
    access.data <= ~access.data;
    access.splitFirst <= 1'b0;
    access.splitSecond <= 1'b0;
  endtask
endmodule

// [sim/data_address_value_compare_debug_chk.sv]
// Port checker for the data address and value compare logic.
`timescale 1ns/1ps

module data_address_value_compare_debug_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire dac_dvc_pkg::apb_req_t apbReq,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire dac_dvc_pkg::access_t access,
  input wire dac_dvc_pkg::event_t eventOut
);
  // ****************************************************************
  // Access classes and assertions.
  // ****************************************************************
  logic rdKind;
  logic wrKind;
  logic clsKind;
  logic strNone;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  assign rdKind = access.valid && access.kind inside {5'h00, [5'h04:5'h07]};
  assign wrKind = access.valid && access.kind inside {5'h01, [5'h08:5'h0c]};
  assign clsKind = access.valid && access.kind >= 5'h0d;
  assign strNone = access.valid && access.kind inside {5'h02, 5'h03} &&
    access.strLen == 7'h0;

  reset_clear_a: assert property (disable iff (1'b0)
    rst |=> eventOut == '0 && prdata == 32'h0 && !pslverr)
    else $error("outputs not cleared by reset");
  class_silent_a: assert property (
    clsKind |=> eventOut.hitMask == 4'h0)
    else $error("class operation raised a hit");
  empty_string_a: assert property (
    strNone |=> eventOut.hitMask == 4'h0)
    else $error("zero length string raised a hit");
  read_only_a: assert property (
    rdKind |=> eventOut.hitMask[3:2] == 2'b00)
    else $error("read access raised a write hit");
  write_only_a: assert property (
    wrKind |=> eventOut.hitMask[1:0] == 2'b00)
    else $error("write access raised a read hit");
  idle_quiet_a: assert property (
    !access.valid |=> eventOut.hitMask == 4'h0 && !eventOut.stopCore)
    else $error("hit without an access");
  stop_first_a: assert property (
    eventOut.stopCore |-> $past(access.valid) && $past(access.splitFirst) &&
    eventOut.hitMask != 4'h0)
    else $error("stop without a first part hit");
  second_dropped_a: assert property (
    eventOut.stopCore && access.valid && access.splitSecond |=>
    eventOut.hitMask == 4'h0)
    else $error("second part hit after stop");
  unmapped_err_a: assert property (
    apbReq.psel && !apbReq.penable && apbReq.paddr > 8'h18 |=> pslverr)
    else $error("unmapped address without error");
endmodule

bind data_address_value_compare_debug data_address_value_compare_debug_chk
  chk (.core_clk(core_clk), .rst(rst), .apbReq(apbReq), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .access(access),
  .eventOut(eventOut));

// [sim/data_address_value_compare_debug_tb_top.sv]
// Testbench for the data address and value compare logic.
`timescale 1ns/1ps

module data_address_value_compare_debug_tb_top;
  // ****************************************************************
  // Signals, instances and tasks.
  // ****************************************************************
  logic core_clk;
  logic rst;
  dac_dvc_pkg::apb_req_t apbReq;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  dac_dvc_pkg::access_t access;
  dac_dvc_pkg::event_t eventOut;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rdData;
  logic slvErr;

  data_address_value_compare_debug dut (.core_clk(core_clk), .rst(rst),
    .apbReq(apbReq), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .access(access), .eventOut(eventOut));
  core_access_model core (.core_clk(core_clk), .access(access));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    comparisons++;
    if (seen !== expd) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rdData = prdata;
    slvErr = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdData, e);
  endtask

  task automatic hit(input dac_dvc_pkg::acc_kind_t k, input logic [31:0] a,
    input logic [31:0] d, input logic [6:0] len, input logic [3:0] e);
    core.send(k, a, d, len, 2'b00);
    core.idle();
    #1;
    check({28'h0, eventOut.hitMask}, {28'h0, e});
  endtask

  task automatic split(input logic [31:0] a, input logic [31:0] stp,
    input logic [31:0] hm2);
    core.send(dac_dvc_pkg::ACC_STORE, a, 32'h0, 7'h0, 2'b01);
    core.send(dac_dvc_pkg::ACC_STORE, a + 32'h2, 32'h0, 7'h0, 2'b10);
    #1;
    check({31'h0, eventOut.stopCore}, stp);
    core.idle();
    #1;
    check({28'h0, eventOut.hitMask}, hm2);
  endtask

  // Control word from enables, sizes, {exclusive, range}, enables, modes.
  function automatic logic [31:0] cw(input logic [3:0] en,
    input logic [3:0] sz, input logic [1:0] rg, input logic [7:0] be,
    input logic [3:0] md);
    return {10'h0, md, be, rg, sz, en};
  endfunction

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    int b;
    int pulses;
    logic [31:0] rAddr[5];
    logic [3:0] rInc[5];
    logic [3:0] rExc[5];
    logic [67:0] kExp;
    logic [39:0] vTab[10];
    rAddr = '{32'h1ff, 32'h200, 32'h2ff, 32'h300, 32'hffffffff};
    rInc = '{4'h0, 4'h3, 4'h3, 4'h0, 4'h0};
    rExc = '{4'h4, 4'h0, 4'h0, 4'h4, 4'h4};
    kExp = 68'h0000ccccc333303c3;
    vTab = '{40'hf511223344, 40'hf411223300, 40'h1511000000,
      40'hf611223344, 40'hf900000044, 40'he811000000, 40'hfd11220000,
      40'hfd00003344, 40'hfc11000044, 40'hf011223344};
    apbReq = '0;
    rst = 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), 32'h0);
    end
    rd(8'h1c, 32'h0);
    check({31'h0, slvErr}, 32'h1);
    wr(dac_dvc_pkg::OFF_CTRL, 32'hffffffff);
    rd(dac_dvc_pkg::OFF_CTRL, dac_dvc_pkg::CTRL_WMASK);
    wr(dac_dvc_pkg::OFF_ADDR_A, 32'h100);
    for (int s = 0; s < 4; s++) begin
      b = (s == 3) ? 5 : s;
      wr(dac_dvc_pkg::OFF_CTRL, cw(4'h1, 4'(s), 2'h0, 8'h0, 4'h0));
      hit(dac_dvc_pkg::ACC_LOAD, 32'h100 + (1 << b) - 1, 32'h0, 7'h0,
        4'h1);
      hit(dac_dvc_pkg::ACC_LOAD, 32'h100 + (1 << b), 32'h0, 7'h0,
        4'h0);
    end
    wr(dac_dvc_pkg::OFF_ADDR_A, 32'h200);
    wr(dac_dvc_pkg::OFF_ADDR_B, 32'h300);
    wr(dac_dvc_pkg::OFF_CTRL, cw(4'h0, 4'hf, 2'h1, 8'h0, 4'h0));
    hit(dac_dvc_pkg::ACC_LOAD, 32'h250, 32'h0, 7'h0, 4'h0);
    for (int x = 0; x < 2; x++) begin
      wr(dac_dvc_pkg::OFF_CTRL,
        cw(x ? 4'h4 : 4'h3, 4'hf, {1'(x), 1'b1}, 8'h0, 4'h0));
      for (int j = 0; j < 5; j++) begin
        hit(x ? dac_dvc_pkg::ACC_STORE : dac_dvc_pkg::ACC_LOAD, rAddr[j],
          32'h0, 7'h0, x ? rExc[j] : rInc[j]);
      end
    end
    wr(dac_dvc_pkg::OFF_ADDR_A, 32'h400);
    wr(dac_dvc_pkg::OFF_ADDR_B, 32'h400);
    wr(dac_dvc_pkg::OFF_CTRL, cw(4'hf, 4'ha, 2'h0, 8'h0, 4'h0));
    for (int k = 0; k < 17; k++) begin
      hit(dac_dvc_pkg::acc_kind_t'(k), 32'h400, 32'h0, (k == 3) ? 7'h0 : 7'h4,
        kExp[k * 4 +: 4]);
    end
    hit(dac_dvc_pkg::ACC_STR_LOAD, 32'h402, 32'h0, 7'h7, 4'h3);
    check({29'h0, eventOut.strBytes}, 32'h2);
    wr(dac_dvc_pkg::OFF_ADDR_A, 32'h500);
    wr(dac_dvc_pkg::OFF_VALUE_A, 32'h11223344);
    wr(dac_dvc_pkg::OFF_STATUS, 32'h1f);
    for (int v = 0; v < 10; v++) begin
      wr(dac_dvc_pkg::OFF_CTRL, cw(4'h1, 4'h0, 2'h0, {4'h0, vTab[v][39:36]},
        {2'h0, vTab[v][35:34]}));
      hit(dac_dvc_pkg::ACC_LOAD, 32'h500 + vTab[v][33], vTab[v][31:0], 7'h0,
        {3'h0, vTab[v][32]});
    end
    rd(dac_dvc_pkg::OFF_STATUS, 32'h11);
    wr(dac_dvc_pkg::OFF_STATUS, 32'h1f);
    rd(dac_dvc_pkg::OFF_STATUS, 32'h0);
    pulses = 0;
    wr(dac_dvc_pkg::OFF_MSTATE, 32'h1);
    repeat (8) begin
      #1;
      pulses += eventOut.debugInt;
      @(posedge core_clk);
    end
    check(32'(pulses), 32'h1);
    wr(dac_dvc_pkg::OFF_CTRL, cw(4'h1, 4'h0, 2'h0, 8'h0, 4'h0));
    hit(dac_dvc_pkg::ACC_LOAD, 32'h500, 32'h0, 7'h0, 4'h1);
    check({31'h0, eventOut.debugInt}, 32'h1);
    rd(dac_dvc_pkg::OFF_STATUS, 32'h1);
    wr(dac_dvc_pkg::OFF_ADDR_A, 32'h600);
    wr(dac_dvc_pkg::OFF_CTRL, cw(4'h4, 4'h3, 2'h0, 8'h0, 4'h0));
    split(32'h602, 32'h1, 32'h0);
    split(32'h5fe, 32'h0, 32'h4);
    wr(dac_dvc_pkg::OFF_ADDR_B, 32'h700);
    wr(dac_dvc_pkg::OFF_VALUE_B, 32'h55667788);
    wr(dac_dvc_pkg::OFF_CTRL, cw(4'h8, 4'h0, 2'h0, 8'h30, 4'h4));
    hit(dac_dvc_pkg::ACC_STORE, 32'h700, 32'h5566ffff, 7'h0, 4'h8);
    hit(dac_dvc_pkg::ACC_STORE, 32'h700, 32'h55ff7788, 7'h0, 4'h0);
    tally_and_finish();
  end
endmodule

// [src/dac_dvc_pkg.sv]
// Package with register map, field layout and carrier types of the comparator.
package dac_dvc_pkg;

  // ****************************************************************
  // Register byte addresses.
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ADDR_A = 8'h08;
  localparam logic [7:0] OFF_ADDR_B = 8'h0c;
  localparam logic [7:0] OFF_VALUE_A = 8'h10;
  localparam logic [7:0] OFF_VALUE_B = 8'h14;
  localparam logic [7:0] OFF_MSTATE = 8'h18;

  // ****************************************************************
  // Control register fields.
  // ****************************************************************
  localparam int RD_EN_A_BIT = 0;
  localparam int RD_EN_B_BIT = 1;
  localparam int WR_EN_A_BIT = 2;
  localparam int WR_EN_B_BIT = 3;
  localparam int SIZE_A_LSB = 4;
  localparam int SIZE_B_LSB = 6;
  localparam int RANGE_EN_BIT = 8;
  localparam int RANGE_EXCL_BIT = 9;
  localparam int BE_A_LSB = 10;
  localparam int BE_B_LSB = 14;
  localparam int MODE_A_LSB = 18;
  localparam int MODE_B_LSB = 20;
  localparam logic [31:0] CTRL_WMASK = 32'h003fffff;

  // ****************************************************************
  // Status register fields and machine state field.
  // ****************************************************************
  localparam int RD_HIT_A_BIT = 0;
  localparam int RD_HIT_B_BIT = 1;
  localparam int WR_HIT_A_BIT = 2;
  localparam int WR_HIT_B_BIT = 3;
  localparam int IMPRECISE_BIT = 4;
  localparam int INT_EN_BIT = 0;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam logic [4:0] RESET_STATUS = 5'h00;

  // ****************************************************************
  // Compare size and value mode encodings.
  // ****************************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LINE = 2'h3;
  localparam logic [1:0] MODE_UNDEF = 2'h0;
  localparam logic [1:0] MODE_AND = 2'h1;
  localparam logic [1:0] MODE_OR = 2'h2;
  localparam logic [1:0] MODE_ANDOR = 2'h3;
  localparam logic [31:0] MASK_HALF = 32'hfffffffe;
  localparam logic [31:0] MASK_WORD = 32'hfffffffc;
  localparam logic [31:0] MASK_LINE = 32'hffffffe0;
  localparam logic [2:0] WORD_BYTES = 3'h4;

  // ****************************************************************
  // Kinds of storage access presented by the core.
  // ****************************************************************
  typedef enum logic [4:0] {
    ACC_LOAD = 5'h00,
    ACC_STORE = 5'h01,
    ACC_STR_LOAD = 5'h02,
    ACC_STR_STORE = 5'h03,
    ACC_DLINE_TOUCH = 5'h04,
    ACC_DLINE_TOUCH_ST = 5'h05,
    ACC_ILINE_INVAL = 5'h06,
    ACC_ILINE_TOUCH = 5'h07,
    ACC_DLINE_ALLOC = 5'h08,
    ACC_DLINE_FLUSH = 5'h09,
    ACC_DLINE_INVAL = 5'h0a,
    ACC_DLINE_STORE = 5'h0b,
    ACC_DLINE_ZERO = 5'h0c,
    ACC_DCLASS_INVAL = 5'h0d,
    ACC_DCACHE_READ = 5'h0e,
    ACC_ICLASS_INVAL = 5'h0f,
    ACC_ICACHE_READ = 5'h10
  } acc_kind_t;

  // Pending-interrupt state.
  typedef enum logic [0:0] {
    PEND_IDLE = 1'b0,
    PEND_WAIT = 1'b1
  } pend_state_t;

  // One storage access as seen by the comparator.
  typedef struct packed {
    logic valid;
    acc_kind_t kind;
    logic [31:0] addr;
    logic [31:0] data;
    logic [6:0] strLen;
    logic splitFirst;
    logic splitSecond;
  } access_t;

  // Event report back to the core.
  typedef struct packed {
    logic debugInt;
    logic stopCore;
    logic [3:0] hitMask;
    logic [2:0] strBytes;
  } event_t;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// [src/data_address_value_compare_debug.sv]
// Data address and value compare debug logic with APB register access.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps

module data_address_value_compare_debug (
  input wire logic core_clk,
  input wire logic rst,
  input wire dac_dvc_pkg::apb_req_t apbReq,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire dac_dvc_pkg::access_t access,
  output dac_dvc_pkg::event_t eventOut
);

  // ****************************************************************
  // Compare helpers.
  // ****************************************************************
  function automatic logic exactHit(input logic [31:0] ea,
                                    input logic [31:0] cmpAddr,
                                    input logic [1:0] size);
    logic [31:0] mask;
    mask = '1;
    case (size)
      dac_dvc_pkg::SIZE_BYTE: mask = '1;
      dac_dvc_pkg::SIZE_HALF: mask = dac_dvc_pkg::MASK_HALF;
      dac_dvc_pkg::SIZE_WORD: mask = dac_dvc_pkg::MASK_WORD;
      dac_dvc_pkg::SIZE_LINE: mask = dac_dvc_pkg::MASK_LINE;
      default: mask = '1;
    endcase
    return ((ea & mask) == (cmpAddr & mask));
  endfunction

  function automatic logic valueHit(input logic [1:0] mode,
                                    input logic [3:0] be,
                                    input logic [31:0] cmpVal,
                                    input logic [31:0] data);
    logic [3:0] eq;
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      eq[i] = (cmpVal[31-8*i -: 8] == data[31-8*i -: 8]);
    end
    case (mode)
      dac_dvc_pkg::MODE_AND: hit = &(~be | eq);
      dac_dvc_pkg::MODE_OR: hit = |(be & eq);
      dac_dvc_pkg::MODE_ANDOR: begin
        hit = (be[0] & eq[0] & be[1] & eq[1]) |
              (be[2] & eq[2] & be[3] & eq[3]);
      end
      dac_dvc_pkg::MODE_UNDEF: hit = 1'b0;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [31:0] ctrl;
  logic [31:0] addrA;
  logic [31:0] addrB;
  logic [31:0] valueA;
  logic [31:0] valueB;
  logic intEnable;
  logic [4:0] status;
  logic [31:0] next_ctrl;
  logic [31:0] next_addrA;
  logic [31:0] next_addrB;
  logic [31:0] next_valueA;
  logic [31:0] next_valueB;
  logic next_intEnable;
  logic [4:0] next_status;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // ****************************************************************
  // Control fields.
  // ****************************************************************
  logic rdEnA;
  logic rdEnB;
  logic wrEnA;
  logic wrEnB;
  logic [1:0] sizeA;
  logic [1:0] sizeB;
  logic rangeEn;
  logic rangeExcl;
  logic [3:0] beA;
  logic [3:0] beB;
  logic [1:0] modeA;
  logic [1:0] modeB;

  assign rdEnA = ctrl[dac_dvc_pkg::RD_EN_A_BIT];
  assign rdEnB = ctrl[dac_dvc_pkg::RD_EN_B_BIT];
  assign wrEnA = ctrl[dac_dvc_pkg::WR_EN_A_BIT];
  assign wrEnB = ctrl[dac_dvc_pkg::WR_EN_B_BIT];
  assign sizeA = ctrl[dac_dvc_pkg::SIZE_A_LSB +: 2];
  assign sizeB = ctrl[dac_dvc_pkg::SIZE_B_LSB +: 2];
  assign rangeEn = ctrl[dac_dvc_pkg::RANGE_EN_BIT];
  assign rangeExcl = ctrl[dac_dvc_pkg::RANGE_EXCL_BIT];
  assign beA = ctrl[dac_dvc_pkg::BE_A_LSB +: 4];
  assign beB = ctrl[dac_dvc_pkg::BE_B_LSB +: 4];
  assign modeA = ctrl[dac_dvc_pkg::MODE_A_LSB +: 2];
  assign modeB = ctrl[dac_dvc_pkg::MODE_B_LSB +: 2];

  // ****************************************************************
  // Access classification and address compare.
  // ****************************************************************
  logic isRead;
  logic isWrite;
  logic strOp;
  logic eligible;
  logic [2:0] strBytes;
  logic [2:0] toWordEnd;
  logic stopPending;
  logic next_stopPending;
  logic rangeActive;
  logic rangeHit;
  logic addrHitA;
  logic addrHitB;
  logic chanHitA;
  logic chanHitB;
  logic [3:0] hitMask;
  logic anyEvent;

  always_comb begin
    isRead = 1'b0;
    isWrite = 1'b0;
    strOp = 1'b0;
    case (access.kind)
      dac_dvc_pkg::ACC_LOAD: isRead = 1'b1;
      dac_dvc_pkg::ACC_STORE: isWrite = 1'b1;
      dac_dvc_pkg::ACC_STR_LOAD: begin
        isRead = 1'b1;
        strOp = 1'b1;
      end
      dac_dvc_pkg::ACC_STR_STORE: begin
        isWrite = 1'b1;
        strOp = 1'b1;
      end
      dac_dvc_pkg::ACC_DLINE_TOUCH,
      dac_dvc_pkg::ACC_DLINE_TOUCH_ST,
      dac_dvc_pkg::ACC_ILINE_INVAL,
      dac_dvc_pkg::ACC_ILINE_TOUCH: isRead = 1'b1;
      dac_dvc_pkg::ACC_DLINE_ALLOC,
      dac_dvc_pkg::ACC_DLINE_FLUSH,
      dac_dvc_pkg::ACC_DLINE_INVAL,
      dac_dvc_pkg::ACC_DLINE_STORE,
      dac_dvc_pkg::ACC_DLINE_ZERO: isWrite = 1'b1;
      default: begin
        isRead = 1'b0;
        isWrite = 1'b0;
      end
    endcase
  end

  // A string chunk runs from its address to the end of the aligned word, or for strLen bytes if that is fewer.
  always_comb begin
    toWordEnd = dac_dvc_pkg::WORD_BYTES - {1'b0, access.addr[1:0]};
    if (!strOp) begin
      strBytes = 3'h0;
    end else if (access.strLen < {4'h0, toWordEnd}) begin
      strBytes = access.strLen[2:0];
    end else begin
      strBytes = toWordEnd;
    end
  end

  assign eligible = access.valid &&
                    !(strOp && access.strLen == 7'h00) &&
                    !(access.splitSecond && stopPending);

  always_comb begin
    rangeActive = rangeEn && (rdEnA || rdEnB || wrEnA || wrEnB);
    if (rangeExcl) begin
      rangeHit = (access.addr < addrA) || (access.addr >= addrB);
    end else begin
      rangeHit = (access.addr >= addrA) && (access.addr < addrB);
    end
    if (rangeEn) begin
      addrHitA = rangeActive && rangeHit;
      addrHitB = rangeActive && rangeHit;
    end else begin
      addrHitA = exactHit(access.addr, addrA, sizeA);
      addrHitB = exactHit(access.addr, addrB, sizeB);
    end
    // Each channel's address result gates its value compare; in range mode both share one result.
    chanHitA = addrHitA &&
               ((beA == 4'h0) ||
                valueHit(modeA, beA, valueA, access.data));
    chanHitB = addrHitB &&
               ((beB == 4'h0) ||
                valueHit(modeB, beB, valueB, access.data));
    hitMask[dac_dvc_pkg::RD_HIT_A_BIT] = eligible && isRead &&
                                         rdEnA && chanHitA;
    hitMask[dac_dvc_pkg::RD_HIT_B_BIT] = eligible && isRead &&
                                         rdEnB && chanHitB;
    hitMask[dac_dvc_pkg::WR_HIT_A_BIT] = eligible && isWrite &&
                                         wrEnA && chanHitA;
    hitMask[dac_dvc_pkg::WR_HIT_B_BIT] = eligible && isWrite &&
                                         wrEnB && chanHitB;
    anyEvent = |hitMask;
  end

  // ****************************************************************
  // Split access stop and debug interrupt pending.
  // ****************************************************************
  dac_dvc_pkg::pend_state_t pend;
  dac_dvc_pkg::pend_state_t next_pend;
  dac_dvc_pkg::event_t next_eventOut;

  always_comb begin
    next_stopPending = stopPending;
    if (access.valid && access.splitFirst) begin
      next_stopPending = anyEvent;
    end else if (access.valid && access.splitSecond) begin
      next_stopPending = 1'b0;
    end
    next_pend = pend;
    next_eventOut = '0;
    next_eventOut.hitMask = hitMask;
    next_eventOut.strBytes = strBytes;
    next_eventOut.stopCore = anyEvent && access.splitFirst;
    case (pend)
      dac_dvc_pkg::PEND_IDLE: begin
        if (anyEvent && !intEnable) begin
          next_pend = dac_dvc_pkg::PEND_WAIT;
        end else if (anyEvent) begin
          next_eventOut.debugInt = 1'b1;
        end
      end
      dac_dvc_pkg::PEND_WAIT: begin
        if (intEnable) begin
          next_eventOut.debugInt = 1'b1;
          next_pend = dac_dvc_pkg::PEND_IDLE;
        end
      end
      default: next_pend = dac_dvc_pkg::PEND_IDLE;
    endcase
  end

  // ****************************************************************
  // APB register access.
  // ****************************************************************
  logic setup;
  logic wrAccess;
  logic mapped;

  assign setup = apbReq.psel && !apbReq.penable;
  assign wrAccess = apbReq.psel && apbReq.penable && apbReq.pwrite &&
                    !pslverr;
  assign pready = 1'b1;

  always_comb begin
    case (apbReq.paddr)
      dac_dvc_pkg::OFF_CTRL,
      dac_dvc_pkg::OFF_STATUS,
      dac_dvc_pkg::OFF_ADDR_A,
      dac_dvc_pkg::OFF_ADDR_B,
      dac_dvc_pkg::OFF_VALUE_A,
      dac_dvc_pkg::OFF_VALUE_B,
      dac_dvc_pkg::OFF_MSTATE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    next_ctrl = ctrl;
    next_addrA = addrA;
    next_addrB = addrB;
    next_valueA = valueA;
    next_valueB = valueB;
    next_intEnable = intEnable;
    next_status = status;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (setup) begin
      next_pslverr = !mapped;
      case (apbReq.paddr)
        dac_dvc_pkg::OFF_CTRL: next_prdata = ctrl;
        dac_dvc_pkg::OFF_STATUS: next_prdata = {27'h0, status};
        dac_dvc_pkg::OFF_ADDR_A: next_prdata = addrA;
        dac_dvc_pkg::OFF_ADDR_B: next_prdata = addrB;
        dac_dvc_pkg::OFF_VALUE_A: next_prdata = valueA;
        dac_dvc_pkg::OFF_VALUE_B: next_prdata = valueB;
        dac_dvc_pkg::OFF_MSTATE: next_prdata = {31'h0, intEnable};
        default: next_prdata = 32'h00000000;
      endcase
    end
    if (wrAccess) begin
      case (apbReq.paddr)
        dac_dvc_pkg::OFF_CTRL: begin
          next_ctrl = apbReq.pwdata & dac_dvc_pkg::CTRL_WMASK;
        end
        dac_dvc_pkg::OFF_STATUS: begin
          next_status = status & ~apbReq.pwdata[4:0];
        end
        dac_dvc_pkg::OFF_ADDR_A: next_addrA = apbReq.pwdata;
        dac_dvc_pkg::OFF_ADDR_B: next_addrB = apbReq.pwdata;
        dac_dvc_pkg::OFF_VALUE_A: next_valueA = apbReq.pwdata;
        dac_dvc_pkg::OFF_VALUE_B: next_valueB = apbReq.pwdata;
        dac_dvc_pkg::OFF_MSTATE: begin
          next_intEnable = apbReq.pwdata[dac_dvc_pkg::INT_EN_BIT];
        end
        default: next_ctrl = ctrl;
      endcase
    end
    // Hardware sets win over a clear in the same cycle.
    next_status[3:0] = next_status[3:0] | hitMask;
    if (anyEvent && !intEnable) begin
      next_status[dac_dvc_pkg::IMPRECISE_BIT] = 1'b1;
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= dac_dvc_pkg::RESET_WORD;
      addrA <= dac_dvc_pkg::RESET_WORD;
      addrB <= dac_dvc_pkg::RESET_WORD;
      valueA <= dac_dvc_pkg::RESET_WORD;
      valueB <= dac_dvc_pkg::RESET_WORD;
      intEnable <= 1'b0;
      status <= dac_dvc_pkg::RESET_STATUS;
      prdata <= dac_dvc_pkg::RESET_WORD;
      pslverr <= 1'b0;
      stopPending <= 1'b0;
      pend <= dac_dvc_pkg::PEND_IDLE;
      eventOut <= '0;
    end else begin
      ctrl <= next_ctrl;
      addrA <= next_addrA;
      addrB <= next_addrB;
      valueA <= next_valueA;
      valueB <= next_valueB;
      intEnable <= next_intEnable;
      status <= next_status;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      stopPending <= next_stopPending;
      pend <= next_pend;
      eventOut <= next_eventOut;
    end
  end

endmodule
